// ---- src/gate_ctl_params.svh ----
// timing constants and register map of the gate-driver controller
`ifndef GATE_CTL_PARAMS_SVH
`define GATE_CTL_PARAMS_SVH

`define CLK_PERIOD_NS     10
`define MIN_PULSE_NS      500
`define MIN_PULSE_CYC     (((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define CNT_W             16

`define REG_CTRL          8'h00
`define REG_STAT          8'h04
`define REG_HOLD          8'h08
`define REG_FLTHOLD       8'h0C

`define CTRL_HIGH_BIT     0
`define CTRL_LOW_BIT      1
`define CTRL_CLEAR_BIT    2
`define CTRL_PULL_BIT     3
`define CTRL_START_BIT    4

`define HOLD_RESET        16'h0040
`define FLTHOLD_RESET     16'h0040

`endif

// ---- src/gate_ctl_pkg.sv ----
// types shared by the gate-driver controller
package gate_ctl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_CHARGE = 3'b011,
    ST_RELAX  = 3'b010,
    ST_RUN    = 3'b110
  } ctl_state_t;
endpackage

// ---- src/pin_sync.sv ----
// three-stage synchroniser with agreement check
`timescale 1ns/1ns
module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // pin
  input  wire logic pin_in,
  output logic      level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 1'b1;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule

// ---- src/gate_ctl_host.sv ----
// processor-side controller driving a half-bridge gate driver
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "gate_ctl_params.svh"
module gate_ctl_host
  import gate_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // axi4-lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // driver pins
  output logic             HIGH_SIDE_CMD,
  output logic             LOW_SIDE_CMD,
  output logic             FAULT_CLEAR_IN,
  input  wire logic        FAULT_LINE_I,
  output logic             FAULT_LINE_O,
  output logic             FAULT_LINE_OE_N
);
  ctl_state_t  state_q;
  logic [`CNT_W-1:0] hold_q;
  logic [`CNT_W-1:0] flthold_q;
  logic [`CNT_W-1:0] cmd_cnt_q;
  logic [`CNT_W-1:0] clr_cnt_q;
  logic [`CNT_W-1:0] pull_cnt_q;
  logic [`CNT_W-1:0] st_cnt_q;
  logic        want_high_q;
  logic        want_low_q;
  logic        want_pull_q;
  logic        clr_req_q;
  logic        clr_busy_q;
  logic        fault_seen_q;
  logic        fault_lvl;
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic        wr_fire;
  logic        cmd_ok;

  pin_sync u_fault_sync (
    .clk     (CLK),
    .reset_n (RESET_N),
    .pin_in  (FAULT_LINE_I),
    .level_q (fault_lvl)
  );

  // clamp a programmed hold to the legal minimum
  function automatic logic [`CNT_W-1:0] min_hold(input logic [`CNT_W-1:0] v);
    if (v < `CNT_W'(`MIN_PULSE_CYC)) begin
      return `CNT_W'(`MIN_PULSE_CYC);
    end
    return v;
  endfunction

  // write channel: address and data accepted in either order
  assign wr_fire = aw_q && w_q && !S_AXI_BVALID;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb0_q      <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_q          <= 1'b1;
        awaddr_q      <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_q          <= 1'b1;
        wdata_q      <= S_AXI_WDATA;
        wstrb0_q     <= S_AXI_WSTRB[0];
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (awaddr_q == `REG_CTRL || awaddr_q == `REG_HOLD ||
            awaddr_q == `REG_FLTHOLD) begin
          S_AXI_BRESP <= 2'h0;
        end else if (awaddr_q == `REG_STAT) begin
          S_AXI_BRESP <= 2'h0;
        end else begin
          S_AXI_BRESP <= 2'h2;
        end
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // software settings; hold times never go below the driver's minimum
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      want_high_q <= 1'b0;
      want_low_q  <= 1'b0;
      want_pull_q <= 1'b0;
      hold_q      <= `HOLD_RESET;
      flthold_q   <= `FLTHOLD_RESET;
    end else if (wr_fire && wstrb0_q) begin
      if (awaddr_q == `REG_CTRL) begin
        want_high_q <= wdata_q[`CTRL_HIGH_BIT];
        want_low_q  <= wdata_q[`CTRL_LOW_BIT];
        want_pull_q <= wdata_q[`CTRL_PULL_BIT];
      end else if (awaddr_q == `REG_HOLD) begin
        hold_q <= min_hold({wdata_q[15:8], wdata_q[7:0]});
      end else if (awaddr_q == `REG_FLTHOLD) begin
        flthold_q <= min_hold({wdata_q[15:8], wdata_q[7:0]});
      end
    end
  end

  // read channel
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= 2'h0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= 2'h0;
      if (S_AXI_ARADDR == `REG_CTRL) begin
        S_AXI_RDATA <= {27'h0, 1'b0, want_pull_q, clr_busy_q,
                        want_low_q, want_high_q};
      end else if (S_AXI_ARADDR == `REG_STAT) begin
        S_AXI_RDATA <= {24'h0, 1'b0, state_q, fault_seen_q,
                        LOW_SIDE_CMD, HIGH_SIDE_CMD, fault_lvl};
      end else if (S_AXI_ARADDR == `REG_HOLD) begin
        S_AXI_RDATA <= {16'h0, hold_q};
      end else if (S_AXI_ARADDR == `REG_FLTHOLD) begin
        S_AXI_RDATA <= {16'h0, flthold_q};
      end else begin
        S_AXI_RDATA <= 32'h00000000;
        S_AXI_RRESP <= 2'h2;
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // start-up: confirm fault high, charge bootstrap, release
  // start-up sequence
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q  <= ST_IDLE;
      st_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_fire && awaddr_q == `REG_CTRL &&
              wdata_q[`CTRL_START_BIT]) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (fault_lvl) begin
            state_q  <= ST_CHARGE;
            st_cnt_q <= '0;
          end
        end
        ST_CHARGE: begin
          st_cnt_q <= st_cnt_q + 1'b1;
          if (st_cnt_q + 1'b1 >= hold_q) begin
            state_q  <= ST_RELAX;
            st_cnt_q <= '0;
          end
        end
        ST_RELAX: begin
          st_cnt_q <= st_cnt_q + 1'b1;
          if (st_cnt_q + 1'b1 >= hold_q) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // a pin may change only after its level has stood the hold time
  assign cmd_ok = (cmd_cnt_q >= hold_q);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HIGH_SIDE_CMD <= 1'b0;
      LOW_SIDE_CMD  <= 1'b0;
      cmd_cnt_q     <= '0;
    end else begin
      logic nh;
      logic nl;
      nh = 1'b0;
      nl = 1'b0;
      if (state_q == ST_CHARGE) begin
        nl = 1'b1;
      end else if (state_q == ST_RUN) begin
        // never request both; a trip from the driver forces both low
        // fault line gates commands
        nh = want_high_q && !want_low_q && fault_lvl;
        nl = want_low_q && !want_high_q && fault_lvl;
      end
      if ((nh != HIGH_SIDE_CMD || nl != LOW_SIDE_CMD) && cmd_ok) begin
        HIGH_SIDE_CMD <= nh;
        LOW_SIDE_CMD  <= nl;
        cmd_cnt_q     <= '0;
      end else if (!cmd_ok) begin
        cmd_cnt_q <= cmd_cnt_q + 1'b1;
      end
    end
  end

  // fault-clear request: the set wins over the request being taken
  // clear pulse longer than minimum
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clr_req_q      <= 1'b0;
      clr_busy_q     <= 1'b0;
      clr_cnt_q      <= '0;
      FAULT_CLEAR_IN <= 1'b0;
    end else begin
      if (wr_fire && awaddr_q == `REG_CTRL && wdata_q[`CTRL_CLEAR_BIT]) begin
        clr_req_q <= 1'b1;
      end else if (clr_req_q && !clr_busy_q) begin
        clr_req_q <= 1'b0;
      end
      if (clr_req_q && !clr_busy_q) begin
        clr_busy_q     <= 1'b1;
        FAULT_CLEAR_IN <= 1'b1;
        clr_cnt_q      <= '0;
      end else if (clr_busy_q) begin
        clr_cnt_q <= clr_cnt_q + 1'b1;
        if (clr_cnt_q + 1'b1 >= hold_q) begin
          FAULT_CLEAR_IN <= 1'b0;
          clr_busy_q     <= 1'b0;
        end
      end
    end
  end

  // open-drain pull: once started it lasts at least the fault hold time
  // pull held past filter time
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAULT_LINE_O    <= 1'b0;
      FAULT_LINE_OE_N <= 1'b1;
      pull_cnt_q      <= '0;
    end else if (!FAULT_LINE_OE_N) begin
      if (pull_cnt_q < flthold_q) begin
        pull_cnt_q <= pull_cnt_q + 1'b1;
      end else if (!want_pull_q) begin
        FAULT_LINE_OE_N <= 1'b1;
      end
    end else if (want_pull_q) begin
      FAULT_LINE_OE_N <= 1'b0;
      pull_cnt_q      <= '0;
    end
  end

  // sticky fault seen; a new low wins over the clear
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fault_seen_q <= 1'b0;
    end else if (!fault_lvl) begin
      fault_seen_q <= 1'b1;
    end else if (clr_busy_q) begin
      fault_seen_q <= 1'b0;
    end
  end

  // both commands must never be driven high at once
  a_no_both_high: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    !(HIGH_SIDE_CMD && LOW_SIDE_CMD))
    else $error("both commands high");

  a_cmd_hold: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    ($changed(HIGH_SIDE_CMD) || $changed(LOW_SIDE_CMD)) |->
    $past(cmd_cnt_q) >= `CNT_W'(`MIN_PULSE_CYC))
    else $error("command changed too early");

  a_clear_width: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    $fell(FAULT_CLEAR_IN) |-> $past(clr_cnt_q) + 1'b1 >= `CNT_W'(`MIN_PULSE_CYC))
    else $error("clear pulse too short");

  a_pull_width: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    $rose(FAULT_LINE_OE_N) |-> $past(pull_cnt_q) >= `CNT_W'(`MIN_PULSE_CYC))
    else $error("fault pull too short");

  a_charge_low: assert property (
    @(posedge CLK) disable iff (!RESET_N)
    (state_q == ST_CHARGE) |-> !HIGH_SIDE_CMD)
    else $error("high command during charge");
endmodule

// ---- tb/gate_drv_model.sv ----
// behavioural half-bridge gate driver seen at the controller's pins
`timescale 1ns/1ns
module gate_drv_model #(
  parameter int FILT = 20,
  parameter int MINW = 50,
  parameter int UVT  = 800
) (
  // sampling clock
  input  wire logic clk,
  // pins from the controller
  input  wire logic high_side_cmd,
  input  wire logic low_side_cmd,
  input  wire logic fault_clear_in,
  input  wire logic fault_line,
  // supply and sense conditions
  input  wire logic overcurrent_sense,
  input  wire logic high_supply_undervolt,
  input  wire logic power_reset_n,
  // outputs
  output logic      fault_pull,
  output logic      high_gate_out,
  output logic      low_gate_out,
  output logic      breach
);
  logic [3:0] raw;
  logic [3:0] filt_q = 4'h8;
  logic [3:0] prev_q = 4'h8;
  logic [3:0] last_q = 4'h8;
  int         cnt_q [4] = '{0, 0, 0, 0};
  int         age_q [4] = '{50, 50, 50, 50};
  int         uv_q = 0;
  logic       fault_q = 0, blk_q = 0, uvblk_q = 0, boot_q = 0;
  logic       hg_q = 0, lg_q = 0, brk_q = 0;
  wire        h = filt_q[0];
  wire        l = filt_q[1];
  wire        shut = !power_reset_n || !filt_q[3] || fault_q;
  assign raw = {fault_line, fault_clear_in, low_side_cmd, high_side_cmd};
  assign high_gate_out = hg_q;
  assign low_gate_out = lg_q;
  assign breach = brk_q;
  assign fault_pull = fault_q && power_reset_n;
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (raw[i] == filt_q[i]) cnt_q[i] <= 0;
      else if (cnt_q[i] >= FILT) filt_q[i] <= raw[i];
      else cnt_q[i] <= cnt_q[i] + 1;
    end
  end
  always @(posedge clk) begin
    last_q <= raw;
    for (int i = 0; i < 3; i++) begin
      if (raw[i] != last_q[i]) age_q[i] <= 0;
      else if (age_q[i] < MINW) age_q[i] <= age_q[i] + 1;
      if (raw[i] != last_q[i] && age_q[i] < MINW) brk_q <= 1'b1;
    end
    if (raw[0] && !boot_q) brk_q <= 1'b1;
    if (raw[1] && !raw[0] && fault_line) boot_q <= 1'b1;
  end
  always @(posedge clk) begin
    prev_q <= filt_q;
    if (!power_reset_n) fault_q <= 1'b0;
    else if (overcurrent_sense && l) fault_q <= 1'b1;
    else if (filt_q[2] && !prev_q[2]) fault_q <= 1'b0;
  end
  always @(posedge clk) begin
    if (!high_supply_undervolt) uv_q <= 0;
    else if (uv_q < UVT) uv_q <= uv_q + 1;
  end
  // lock until a new high edge
  always @(posedge clk) begin
    if (uv_q >= UVT) uvblk_q <= 1'b1;
    else if (!h) uvblk_q <= 1'b0;
  end
  always @(posedge clk) begin
    if (shut) begin
      hg_q <= 1'b0;
      lg_q <= 1'b0;
      blk_q <= 1'b1;
    end else if (blk_q) begin
      blk_q <= h | l;
    end else if (!(h && l) || !(prev_q[0] || prev_q[1])) begin
      hg_q <= h && !uvblk_q;
      lg_q <= l && !h;
    end
  end
endmodule

// ---- tb/test_gate_ctl_host.sv ----
// self-checking bench for the gate-driver controller
`timescale 1ns/1ns
`include "gate_ctl_params.svh"
module test_gate_ctl_host;
  logic        CLK, RESET_N;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        hcmd, lcmd, clr, fl_o, fl_oe_n, fl_pull, hg, lg, brk;
  logic        oc, uv, por_n;
  logic [33:0] exp_q[$], msk_q[$], seen;
  int          miscompares = 0, samples_checked = 0, clr_n = 0, n;
  // open-drain line with pull-up
  wire         fline = (fl_oe_n | fl_o) & !fl_pull;

  gate_ctl_host uut (.CLK(CLK), .RESET_N(RESET_N),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .HIGH_SIDE_CMD(hcmd),
    .LOW_SIDE_CMD(lcmd), .FAULT_CLEAR_IN(clr), .FAULT_LINE_I(fline),
    .FAULT_LINE_O(fl_o), .FAULT_LINE_OE_N(fl_oe_n));
  gate_drv_model mdl (.clk(CLK), .high_side_cmd(hcmd), .low_side_cmd(lcmd),
    .fault_clear_in(clr), .fault_line(fline), .overcurrent_sense(oc),
    .high_supply_undervolt(uv), .power_reset_n(por_n), .fault_pull(fl_pull),
    .high_gate_out(hg), .low_gate_out(lg), .breach(brk));

  task automatic check(input string nm, input logic [33:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    exp_q.push_back({er, 32'h0});
    msk_q.push_back('1);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw | w) begin
      @(posedge CLK);
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end
    bready <= 1'b1;
    do @(posedge CLK); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge CLK); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge CLK); while (!rvalid);
    rready <= 1'b0;
  endtask
  // two hold intervals plus the driver's filter delay
  task automatic settle;
    repeat (150) @(posedge CLK);
  endtask
  task automatic ctl(input logic [31:0] v);
    wr(`REG_CTRL, v, 4'hF, 2'h0);
    settle;
  endtask
  task automatic rearm(input logic [31:0] v);
    ctl(32'h0);
    ctl(v);
  endtask
  task automatic pins(input logic [3:0] e);
    check("pins", {30'h0, hcmd, lcmd, hg, lg}, {30'h0, e});
  endtask

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // the sequence needs about 5600 cycles
  initial begin
    repeat (40000) @(posedge CLK);
    miscompares++;
    finish_test;
  end
  always @(posedge CLK) begin
    clr_n <= clr_n + 32'(clr);
    if ((bvalid && bready) || (rvalid && rready)) begin
      seen = bvalid ? {bresp, 32'h0} : {rresp, rdata};
      check("bus", seen & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  initial begin
    logic [1:0] v, e;
    {awvalid, wvalid, bready, arvalid, rready, oc, uv, RESET_N} = '0;
    {awaddr, araddr, wdata} = '0;
    {wstrb, por_n} = 5'h1F;
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    n = $urandom(93);
    rd(`REG_STAT, 34'h1, 34'h7F);
    rd(`REG_HOLD, 34'h40, 34'hFFFF);
    rd(8'h10, 34'h200000000, '1);
    wr(8'h10, 32'h1, 4'hF, 2'h2);
    wr(`REG_STAT, 32'h7F, 4'hF, 2'h0);
    wr(`REG_HOLD, 32'h5, 4'hF, 2'h0);
    wr(`REG_HOLD, 32'h80, 4'h0, 2'h0);
    rd(`REG_HOLD, 34'(`MIN_PULSE_CYC), 34'hFFFF);
    wr(`REG_FLTHOLD, 32'h10, 4'hF, 2'h0);
    rd(`REG_FLTHOLD, 34'(`MIN_PULSE_CYC), 34'hFFFF);
    ctl(32'h10);
    rd(`REG_STAT, 34'h61, 34'h7F);
    for (int i = 0; i < 8; i++) begin
      v = 2'($urandom_range(0, 3));
      e = {v == 2'h1, v == 2'h2};
      ctl({30'h0, v});
      pins({e, e});
      rd(`REG_STAT, {31'h0, e[0], e[1], 1'b0}, 34'h6);
    end
    rearm(32'h1);
    ctl(32'h9);
    pins(4'h0);
    check("pull", {33'h0, fl_oe_n}, 34'h0);
    rd(`REG_STAT, 34'h0, 34'h1);
    ctl(32'h1);
    pins(4'hA);
    rearm(32'h1);
    oc <= 1'b1;
    settle;
    pins(4'hA);
    check("line", {33'h0, fline}, 34'h1);
    oc <= 1'b0;
    ctl(32'h2);
    oc <= 1'b1;
    repeat (5) @(posedge CLK);
    oc <= 1'b0;
    settle;
    pins(4'h0);
    rd(`REG_STAT, 34'h8, 34'h9);
    n = clr_n;
    ctl(32'h6);
    check("clear", 34'(clr_n - n), 34'(`MIN_PULSE_CYC));
    rd(`REG_STAT, 34'h1, 34'h9);
    pins(4'h5);
    rearm(32'h2);
    pins(4'h5);
    por_n <= 1'b0;
    settle;
    pins(4'h4);
    check("line", {33'h0, fline}, 34'h1);
    por_n <= 1'b1;
    settle;
    pins(4'h4);
    rearm(32'h1);
    uv <= 1'b1;
    repeat (900) @(posedge CLK);
    pins(4'h8);
    ctl(32'h2);
    pins(4'h5);
    ctl(32'h1);
    uv <= 1'b0;
    settle;
    pins(4'h8);
    rearm(32'h1);
    pins(4'hA);
    check("breach", {33'h0, brk}, 34'h0);
    finish_test;
  end
endmodule
